// >>> core/afs_top.v
// Purpose: Filter setup registers with Wishbone access and a channel sequencer.
// Assumes: Channel enables and the setup number of the current channel come from same-clock logic.
// Notes: Every access is acknowledged two cycles after it is seen.
`timescale 1ns/1ps
`include "afs_consts.vh"
module afs_top (
   input wire clk_i,
   input wire rst_i,
   // Wishbone slave port.
   input wire wb_cyc_i,
   input wire wb_stb_i,
   input wire wb_we_i,
   input wire [7:0] wb_adr_i,
   input wire [3:0] wb_sel_i,
   input wire [31:0] wb_dat_i,
   output reg [31:0] wb_dat_o,
   output reg wb_ack_o,
   // Sequencer link to the converter.
   input wire [15:0] chan_enable_i,
   input wire [2:0] ch_setup_i,
   input wire conv_done_i,
   output reg [3:0] channel_o,
   output reg conv_start_o,
   output reg conv_abort_o,
   output reg restart_o,
   output reg running_o,
   // Settings of the conversion in progress.
   output reg [2:0] cfg_setup_o,
   output reg cfg_direct_o,
   output reg cfg_sinc3_o,
   output reg cfg_post_on_o,
   output reg [2:0] cfg_post_sel_o,
   output reg [14:0] cfg_decim_o,
   output reg [4:0] cfg_rate_code_o,
   output reg [23:0] cfg_rate_centi_o,
   output reg [9:0] cfg_settle_o
);
   // Register map by word index; the byte address is four times it.
   // 0x28 to 0x2F: filter setup words 0 to 7, in the low half of the data bus.
   // 0x0E: status, read only. Bit 9 abort seen, bit 8 running,
   // bits 7 to 5 active setup, bits 4 to 1 channel, bit 0 zero.
   // 0x0F: control. Bit 0 lets the sequencer run; it is set out of reset.
   // Any other index is acked, reads zero and drops writes,
   // so a stray host access never hangs the bus.
   //
   // Bus timing: a request is taken at the edge that sees cyc and stb
   // with no access in flight. The next edge writes the word or
   // registers the read data, and ack is high for the cycle after it.
   // Requests in the busy or ack cycle are ignored, so a master that
   // holds stb until it sees ack gets exactly one access.
   // The answer time depends neither on sel nor on the register.
   //
   // Sequencer: IDLE waits for the enable and an enabled channel.
   // LOAD gives the setup memory a cycle to present the new word,
   // APPLY lets the decoder settle, and the edge leaving APPLY
   // latches the settings and pulses conv_start_o. A done pulse in
   // RUN steps to the next enabled channel. A setup write sends the
   // sequencer back to LOAD on the lowest enabled channel from any
   // state while the enable is set, so a stored change never waits for a slow conversion.
   //
   // Reset: every setup word returns to its default, the enable is
   // set and all outputs are low; with a channel enabled the
   // sequencer leaves IDLE at the first edge after release.
   //
   // Limitation: each setup write costs one restart, so software that
   // rewrites an unchanged word still loses the conversion in flight.
   // Sequencer states, one-hot.
   localparam ST_IDLE = 4'h1;
   localparam ST_LOAD = 4'h2;
   localparam ST_APPLY = 4'h4;
   localparam ST_RUN = 4'h8;

   // Captured request, control state and sequencer registers.
   reg [3:0] state_reg;
   reg [3:0] state_next;
   reg busy_reg;
   reg [5:0] idx_reg;
   reg we_reg;
   reg [3:0] sel_reg;
   reg [15:0] wdata_reg;
   reg enable_reg;
   reg abort_seen_reg;
   reg [3:0] channel_next;
   reg [15:0] merged;
   reg [15:0] masked;

   // Bus decode and helper nets.
   wire [5:0] idx = wb_adr_i[7:2];
   // The busy and ack cycles are excluded, so a held strobe counts once.
   wire req = wb_cyc_i && wb_stb_i && !busy_reg && !wb_ack_o;
   wire hit_setup = (idx_reg >= `AFS_IDX_SETUP_FIRST) && (idx_reg <= `AFS_IDX_SETUP_LAST);
   wire hit_status = (idx_reg == `AFS_IDX_STATUS);
   wire hit_control = (idx_reg == `AFS_IDX_CONTROL);
   wire [2:0] setup_sel = idx_reg[2:0];
   wire finish = busy_reg;
   wire setup_write = finish && we_reg && hit_setup;
   wire control_write = finish && we_reg && hit_control && sel_reg[0];
   wire any_enabled = |chan_enable_i;
   wire [15:0] bus_word;
   wire [15:0] flt_word;
   wire dec_direct;
   wire dec_sinc3;
   wire dec_post_on;
   wire [14:0] dec_decim;
   wire [23:0] dec_rate;
   wire [9:0] dec_settle;
   // The edge leaving APPLY both starts a conversion and latches its settings.
   wire leave_apply = (state_reg == ST_APPLY) && (state_next == ST_RUN);
   wire status_read = finish && !we_reg && hit_status;
   // Status layout in one place; the upper bits are always zero.
   wire [31:0] status_word = {22'h00000, abort_seen_reg, running_o, cfg_setup_o, channel_o, 1'b0};

   // Lowest enabled channel, the start of every restarted sequence.
   // The scan runs downwards, so the lowest set bit is the last hit.
   function [3:0] first_chan;
      input [15:0] en;
      integer k;
      begin
         first_chan = 4'h0;
         for (k = 15; k >= 0; k = k - 1) begin
            if (en[k]) begin
               first_chan = k[3:0];
            end
         end
      end
   endfunction

   // Next enabled channel above the current one, wrapping to the lowest.
   // An empty mask gives zero; the sequencer is parked in IDLE then.
   function [3:0] next_chan;
      input [15:0] en;
      input [3:0] cur;
      integer k;
      reg found;
      begin
         found = 1'b0;
         next_chan = first_chan(en);
         for (k = 0; k < 16; k = k + 1) begin
            if (!found && en[k] && (k > cur)) begin
               next_chan = k[3:0];
               found = 1'b1;
            end
         end
      end
   endfunction

   // Setup storage. The bus port is addressed straight from the bus,
   // the filter port by the setup number of the current channel.
   afs_setup_mem u_mem (
      .clk_i(clk_i),
      .rst_i(rst_i),
      .we_i(setup_write),
      .wr_addr_i(setup_sel),
      .wr_data_i(masked),
      .bus_addr_i(idx[2:0]),
      .bus_data_o(bus_word),
      .flt_addr_i(ch_setup_i),
      .flt_data_o(flt_word)
   );

   // The decoder sees the word of the current channel's setup.
   afs_decode u_dec (
      .word_i(flt_word),
      .direct_o(dec_direct),
      .sinc3_o(dec_sinc3),
      .post_on_o(dec_post_on),
      .decim_o(dec_decim),
      .rate_centi_o(dec_rate),
      .settle_o(dec_settle)
   );

   // Bus request capture. The memory reads the addressed word at this same edge, so
   // the stored word is ready when the access finishes one cycle later.
   // Only the low half of the write data is kept; no register is wider.
   always @(posedge clk_i) begin
      if (rst_i) begin
         busy_reg <= 1'b0;
         idx_reg <= 6'h00;
         we_reg <= 1'b0;
         sel_reg <= 4'h0;
         wdata_reg <= 16'h0000;
      end else if (req) begin
         busy_reg <= 1'b1;
         idx_reg <= idx;
         we_reg <= wb_we_i;
         sel_reg <= wb_sel_i;
         wdata_reg <= wb_dat_i[15:0];
      end else if (finish) begin
         busy_reg <= 1'b0;
      end
   end

   // Byte lanes merge into the stored word, then reserved bits are forced low.
   // The mask follows the merged direct bit, since in direct mode bits 14 to 12 carry ratio.
   // A partial write keeps the other lane from storage, which is why the
   // memory must show the addressed word by the finishing cycle.
   always @* begin
      merged = bus_word;
      if (sel_reg[0]) begin
         merged[7:0] = wdata_reg[7:0];
      end
      if (sel_reg[1]) begin
         merged[15:8] = wdata_reg[15:8];
      end
      if (merged[`AFS_BIT_DIRECT]) begin
         masked = merged & `AFS_MASK_DIRECT;
      end else begin
         masked = merged & `AFS_MASK_NORMAL;
      end
   end

   // Acknowledge and read data; unmapped indices read zero and ignore writes.
   // Read data hold after ack until the next read finishes, for a slow master.
   // Ack is registered from the finishing cycle, a fixed two cycles after the request.
   always @(posedge clk_i) begin
      if (rst_i) begin
         wb_ack_o <= 1'b0;
         wb_dat_o <= 32'h00000000;
      end else begin
         wb_ack_o <= finish;
         if (finish && !we_reg) begin
            if (hit_setup) begin
               wb_dat_o <= {16'h0000, bus_word};
            end else if (hit_status) begin
               wb_dat_o <= status_word;
            end else if (hit_control) begin
               wb_dat_o <= {31'h00000000, enable_reg};
            end else begin
               wb_dat_o <= 32'h00000000;
            end
         end
      end
   end

   // Control register: bit 0 lets the sequencer run.
   // Clearing it parks the sequencer; setup words can still be written.
   always @(posedge clk_i) begin
      if (rst_i) begin
         enable_reg <= `AFS_CONTROL_RESET;
      end else if (control_write) begin
         enable_reg <= wdata_reg[0];
      end
   end

   // Sticky abort flag, cleared by a status read; a new abort wins over the clear.
   // It tells software that a write cut a running conversion short.
   always @(posedge clk_i) begin
      if (rst_i) begin
         abort_seen_reg <= 1'b0;
      end else if (setup_write && running_o) begin
         abort_seen_reg <= 1'b1;
      end else if (status_read) begin
         abort_seen_reg <= 1'b0;
      end
   end

   // Sequencer next state. The enable and the channel mask are checked last and win over
   // a setup write: a write while parked still lands in storage and takes effect at the
   // next start.
   always @* begin
      state_next = state_reg;
      channel_next = channel_o;
      case (state_reg)
         ST_IDLE: begin
            if (enable_reg && any_enabled) begin
               state_next = ST_LOAD;
               channel_next = first_chan(chan_enable_i);
            end
         end
         ST_LOAD: begin
            state_next = ST_APPLY;
         end
         ST_APPLY: begin
            state_next = ST_RUN;
         end
         ST_RUN: begin
            if (conv_done_i) begin
               state_next = ST_LOAD;
               channel_next = next_chan(chan_enable_i, channel_o);
            end
         end
         default: begin
            state_next = ST_IDLE;
         end
      endcase
      if (!enable_reg || !any_enabled) begin
         state_next = ST_IDLE;
      end else if (setup_write) begin
         state_next = ST_LOAD;
         channel_next = first_chan(chan_enable_i);
      end
   end

   // Sequencer registers and the one-cycle event outputs.
   // conv_abort_o fires only in RUN; in LOAD or APPLY there is nothing to cut short.
   // running_o follows the next state, so it rises with conv_start_o.
   // A done in the same cycle as a setup write is lost; the restart wins.
   always @(posedge clk_i) begin
      if (rst_i) begin
         state_reg <= ST_IDLE;
         channel_o <= 4'h0;
         conv_start_o <= 1'b0;
         conv_abort_o <= 1'b0;
         restart_o <= 1'b0;
         running_o <= 1'b0;
      end else begin
         state_reg <= state_next;
         channel_o <= channel_next;
         conv_start_o <= leave_apply;
         conv_abort_o <= setup_write && (state_reg == ST_RUN);
         restart_o <= setup_write;
         running_o <= (state_next == ST_RUN);
      end
   end

   // Active settings latch only as a conversion starts, so a stored change waits for the restart.
   // Select and rate fields pass as stored, so the converter can apply its own
   // multichannel table; direct mode and postfilter flags come from the decoder.
   // One set of settings per conversion keeps the filter from changing mid result.
   always @(posedge clk_i) begin
      if (rst_i) begin
         cfg_setup_o <= 3'h0;
         cfg_direct_o <= 1'b0;
         cfg_sinc3_o <= 1'b0;
         cfg_post_on_o <= 1'b0;
         cfg_post_sel_o <= 3'h0;
         cfg_decim_o <= 15'h0000;
         cfg_rate_code_o <= 5'h00;
         cfg_rate_centi_o <= 24'h000000;
         cfg_settle_o <= 10'h000;
      end else if (leave_apply) begin
         cfg_setup_o <= ch_setup_i;
         cfg_direct_o <= dec_direct;
         cfg_sinc3_o <= dec_sinc3;
         cfg_post_on_o <= dec_post_on;
         cfg_post_sel_o <= flt_word[`AFS_POST_SEL_HI:`AFS_POST_SEL_LO];
         cfg_decim_o <= dec_decim;
         cfg_rate_code_o <= flt_word[`AFS_RATE_HI:`AFS_RATE_LO];
         cfg_rate_centi_o <= dec_rate;
         cfg_settle_o <= dec_settle;
      end
   end
endmodule

// >>> core/afs_consts.vh
// Purpose: Shared constants of the filter setup block.
// Assumes: Register indices are word indices; byte address is four times the index.
// Notes: Definitions only.
`ifndef AFS_CONSTS_VH
`define AFS_CONSTS_VH
`define AFS_IDX_SETUP_FIRST 6'h28
`define AFS_IDX_SETUP_LAST 6'h2F
`define AFS_IDX_STATUS 6'h0E
`define AFS_IDX_CONTROL 6'h0F
`define AFS_SETUP_RESET 16'h0500
`define AFS_CONTROL_RESET 1'h1
`define AFS_MASK_NORMAL 16'h8F7F
`define AFS_MASK_DIRECT 16'hFFFF
`define AFS_BIT_DIRECT 15
`define AFS_BIT_POST_EN 11
`define AFS_POST_SEL_HI 10
`define AFS_POST_SEL_LO 8
`define AFS_ORDER_HI 6
`define AFS_ORDER_LO 5
`define AFS_RATE_HI 4
`define AFS_RATE_LO 0
`define AFS_DECIM_HI 14
`define AFS_ORDER_SINC5 2'h0
`define AFS_ORDER_SINC3 2'h3
`define AFS_DIRECT_DIVISOR 6'h20
`endif

// >>> core/afs_setup_mem.v
// Purpose: Storage for the eight filter setup words.
// Assumes: Writer has already masked reserved bits.
// Notes: Both read ports come out of registers, one cycle after the address.
`timescale 1ns/1ps
`include "afs_consts.vh"
module afs_setup_mem (
   input wire clk_i,
   input wire rst_i,
   input wire we_i,
   input wire [2:0] wr_addr_i,
   input wire [15:0] wr_data_i,
   input wire [2:0] bus_addr_i,
   output reg [15:0] bus_data_o,
   input wire [2:0] flt_addr_i,
   output reg [15:0] flt_data_o
);
   reg [15:0] word_reg [0:7];
   genvar g;

   // Each word resets and loads on its own.
   generate
      for (g = 0; g < 8; g = g + 1) begin : gen_word
         always @(posedge clk_i) begin
            if (rst_i) begin
               word_reg[g] <= `AFS_SETUP_RESET;
            end else if (we_i && (wr_addr_i == g)) begin
               word_reg[g] <= wr_data_i;
            end
         end
      end
   endgenerate

   // Registered reads keep the outputs free of decode glitches.
   always @(posedge clk_i) begin
      if (rst_i) begin
         bus_data_o <= `AFS_SETUP_RESET;
         flt_data_o <= `AFS_SETUP_RESET;
      end else begin
         bus_data_o <= word_reg[bus_addr_i];
         flt_data_o <= word_reg[flt_addr_i];
      end
   end
endmodule

// >>> core/afs_decode.v
// Purpose: Turns one setup word into the filter settings it selects.
// Assumes: Input word is stable; output is combinational.
// Notes: Rates are in hundredths of SPS, settling in tenths of ms.
`timescale 1ns/1ps
`include "afs_consts.vh"
module afs_decode (
   input wire [15:0] word_i,
   output wire direct_o,
   output wire sinc3_o,
   output wire post_on_o,
   output wire [14:0] decim_o,
   output reg [23:0] rate_centi_o,
   output reg [9:0] settle_o
);
   wire [1:0] order = word_i[`AFS_ORDER_HI:`AFS_ORDER_LO];
   wire [4:0] code = word_i[`AFS_RATE_HI:`AFS_RATE_LO];
   wire [2:0] psel = word_i[`AFS_POST_SEL_HI:`AFS_POST_SEL_LO];
   wire s3 = (order == `AFS_ORDER_SINC3);
   reg [23:0] base;

   assign direct_o = word_i[`AFS_BIT_DIRECT];
   assign sinc3_o = direct_o | s3;
   assign post_on_o = !direct_o && word_i[`AFS_BIT_POST_EN] && (order == `AFS_ORDER_SINC5);
   // Direct ratio; rate is modulator rate over this times 32, computed outside.
   assign decim_o = direct_o ? word_i[`AFS_DECIM_HI:0] : 15'h0000;

   // Rate table for a single channel; sinc3 entries differ slightly.
   always @* begin
      case (code)
         5'h00, 5'h01: base = 24'hBEBC20;
         5'h02, 5'h03: base = 24'h5F5E10;
         5'h04: base = 24'h2FAF08;
         5'h05: base = 24'h2625A0;
         5'h06: base = 24'h17D784;
         5'h07: base = s3 ? 24'h0FE506 : 24'h0FDAD8;
         5'h08: base = s3 ? 24'h07A120 : 24'h079EC8;
         5'h09: base = s3 ? 24'h03D090 : 24'h03CFC8;
         5'h0A: base = 24'h0186A0;
         5'h0B: base = 24'h00C350;
         5'h0C: base = s3 ? 24'h009C7C : 24'h009A7E;
         5'h0D: base = 24'h004E20;
         5'h0E: base = 24'h002710;
         5'h0F: base = 24'h001763;
         5'h10: base = s3 ? 24'h001388 : 24'h001380;
         5'h11: base = 24'h0007D0;
         5'h12: base = 24'h000683;
         5'h13: base = 24'h0003E8;
         5'h14: base = 24'h0001F4;
         5'h15, 5'h16: base = 24'h0000FA;
         default: base = 24'h000000;
      endcase
      rate_centi_o = base;
      settle_o = 10'h000;
      if (direct_o) begin
         rate_centi_o = 24'h000000;
      end else if (post_on_o) begin
         case (psel)
            3'h2: begin
               rate_centi_o = 24'h000A8C;
               settle_o = 10'h16F;
            end
            3'h3: begin
               rate_centi_o = 24'h0009C4;
               settle_o = 10'h190;
            end
            3'h5: begin
               rate_centi_o = 24'h0007D0;
               settle_o = 10'h1F4;
            end
            3'h6: begin
               rate_centi_o = 24'h000683;
               settle_o = 10'h258;
            end
            default: begin
               rate_centi_o = base;
               settle_o = 10'h000;
            end
         endcase
      end
   end
endmodule

// >>> sim/afs_top_sva.sv
// Purpose: Port-level checks of the filter setup block.
// Assumes: One clock, synchronous active-high reset.
// Notes: Bound onto afs_top after the module.
`timescale 1ns/1ps
module afs_chk (
   input wire logic clk_i,
   input wire logic rst_i,
   input wire logic wb_cyc_i,
   input wire logic wb_stb_i,
   input wire logic wb_we_i,
   input wire logic [7:0] wb_adr_i,
   input wire logic [31:0] wb_dat_o,
   input wire logic wb_ack_o,
   input wire logic [15:0] chan_enable_i,
   input wire logic [2:0] ch_setup_i,
   input wire logic conv_done_i,
   input wire logic [3:0] channel_o,
   input wire logic conv_start_o,
   input wire logic conv_abort_o,
   input wire logic restart_o,
   input wire logic running_o,
   input wire logic [2:0] cfg_setup_o,
   input wire logic cfg_direct_o,
   input wire logic cfg_sinc3_o,
   input wire logic cfg_post_on_o,
   input wire logic [23:0] cfg_rate_centi_o
);
   logic [3:0] first_ch;
   wire setup_hit = wb_adr_i >= 8'hA0 && wb_adr_i <= 8'hBC;
   default clocking cb @(posedge clk_i); endclocking
   default disable iff (rst_i);
   // The scan runs downwards from channel 15, so the lowest set bit is the last hit and wins.
   always_comb begin
      first_ch = 4'h0;
      for (int i = 15; i >= 0; i--) begin
         if (chan_enable_i[i]) begin
            first_ch = i[3:0];
         end
      end
   end
   // Steps of a setup write and of its answer.
   sequence s_req; $rose(wb_stb_i) && wb_cyc_i; endsequence
   sequence s_setup_wr; wb_ack_o && wb_we_i && setup_hit; endsequence
   property p_ack_lat; s_req |-> !wb_ack_o ##[1:2] wb_ack_o; endproperty
   property p_ack_pulse; wb_ack_o |=> !wb_ack_o; endproperty
   property p_rd_upper; wb_ack_o |-> wb_dat_o[31:16] == 16'h0000; endproperty
   property p_restart; s_setup_wr ##0 (|chan_enable_i) |-> restart_o && channel_o == first_ch; endproperty
   property p_restart_cause; restart_o |-> s_setup_wr; endproperty
   property p_abort; conv_abort_o |-> restart_o; endproperty
   property p_start; restart_o && |chan_enable_i |-> ##[1:3] conv_start_o; endproperty
   property p_cfg_hold; !conv_start_o |-> $stable(cfg_setup_o) && $stable(cfg_direct_o); endproperty
   property p_cfg_setup; conv_start_o |-> cfg_setup_o == ch_setup_i; endproperty
   property p_direct; cfg_direct_o |-> cfg_rate_centi_o == 24'h000000 && !cfg_post_on_o; endproperty
   property p_post_order; cfg_post_on_o |-> !cfg_sinc3_o; endproperty
   a_ack_lat: assert property (p_ack_lat) else $error("ack late or missing");
   a_ack_pulse: assert property (p_ack_pulse) else $error("ack longer than one cycle");
   a_rd_upper: assert property (p_rd_upper) else $error("read data upper half not zero");
   a_restart: assert property (p_restart) else $error("setup write did not restart");
   a_restart_cause: assert property (p_restart_cause) else $error("restart without setup write");
   a_abort: assert property (p_abort) else $error("abort without restart");
   a_start: assert property (p_start) else $error("no start after restart");
   a_cfg_hold: assert property (p_cfg_hold) else $error("settings changed mid conversion");
   a_cfg_setup: assert property (p_cfg_setup) else $error("wrong setup for channel");
   a_direct: assert property (p_direct) else $error("options active in direct mode");
   a_post_order: assert property (p_post_order) else $error("postfilter on with sinc3");
endmodule
bind afs_top afs_chk afs_chk_inst (.clk_i, .rst_i, .wb_cyc_i, .wb_stb_i, .wb_we_i, .wb_adr_i, .wb_dat_o,
   .wb_ack_o, .chan_enable_i, .ch_setup_i, .conv_done_i, .channel_o, .conv_start_o, .conv_abort_o,
   .restart_o, .running_o, .cfg_setup_o, .cfg_direct_o, .cfg_sinc3_o, .cfg_post_on_o, .cfg_rate_centi_o);

// >>> sim/afs_conv_model.sv
// Purpose: Conversion engine beside the sequencer.
// Assumes: Conversion time comes from the bench.
// Notes: Channel n uses setup (n+1) mod 8, so a wrong index shows.
`timescale 1ns/1ps
module afs_conv_model (
   input wire logic clk_i,
   input wire logic rst_i,
   input wire logic [7:0] delay_i,
   input wire logic conv_start_i,
   input wire logic conv_abort_i,
   input wire logic [3:0] channel_i,
   output logic [2:0] ch_setup_o,
   output logic conv_done_o
);
   logic [7:0] cnt_reg;
   assign ch_setup_o = channel_i[2:0] + 3'h1;
   assign conv_done_o = cnt_reg == 8'h01;
   // A start reloads the time; an abort drops the conversion so no stale done follows.
   always_ff @(posedge clk_i) begin
      if (rst_i || conv_abort_i) begin
         cnt_reg <= 8'h00;
      end else if (conv_start_i) begin
         cnt_reg <= delay_i;
      end else if (cnt_reg != 8'h00) begin
         cnt_reg <= cnt_reg - 8'h01;
      end
   end
endmodule

// >>> sim/afs_top_tb.sv
// Purpose: Self-checking bench for the filter setup block.
// Assumes: Classic single-cycle bus master.
// Notes: Conversion model closes the sequencer loop.
`timescale 1ns/1ps
module afs_top_tb;
   logic clk_i = 1'b0;
   logic rst_i = 1'b1;
   logic cyc = 1'b0;
   logic stb = 1'b0;
   logic we = 1'b0;
   logic [7:0] adr = 8'h00;
   logic [31:0] wdat = 32'h0;
   logic [31:0] rdat;
   logic [3:0] sel = 4'h0;
   logic [15:0] chan_en = 16'h0001;
   logic [7:0] dly = 8'hC8;
   logic rs_seen, ab_seen;
   wire [31:0] rd_o;
   wire [3:0] channel;
   wire [2:0] ch_setup, cfg_setup, post_sel;
   wire [14:0] decim;
   wire [4:0] rate_code;
   wire [23:0] centi;
   wire [9:0] settle;
   wire ack, done, start, abort, restart, running, direct, sinc3, post_on;
   int errors = 0;
   int n_compared = 0;
   int cycles = 0;
   afs_top afs_top_inst (.clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we),
      .wb_adr_i(adr), .wb_sel_i(sel), .wb_dat_i(wdat), .wb_dat_o(rd_o), .wb_ack_o(ack),
      .chan_enable_i(chan_en), .ch_setup_i(ch_setup), .conv_done_i(done), .channel_o(channel),
      .conv_start_o(start), .conv_abort_o(abort), .restart_o(restart), .running_o(running),
      .cfg_setup_o(cfg_setup), .cfg_direct_o(direct), .cfg_sinc3_o(sinc3), .cfg_post_on_o(post_on),
      .cfg_post_sel_o(post_sel), .cfg_decim_o(decim), .cfg_rate_code_o(rate_code),
      .cfg_rate_centi_o(centi), .cfg_settle_o(settle));
   afs_conv_model afs_conv_model_inst (.clk_i(clk_i), .rst_i(rst_i), .delay_i(dly), .conv_start_i(start),
      .conv_abort_i(abort), .channel_i(channel), .ch_setup_o(ch_setup), .conv_done_o(done));
   // Clock at 40 MHz.
   initial begin
      forever #12.5 clk_i = ~clk_i;
   end
   // A hang counts as a mismatch and ends the run.
   always @(posedge clk_i) begin
      cycles <= cycles + 1;
      if (cycles == 20000) begin
         errors = errors + 1;
         end_sim();
      end
   end
   task automatic end_sim();
      $display("Compared %0d, errors %0d", n_compared, errors);
      if (errors == 0 && n_compared > 0) begin
         $display("Testbench passed");
      end else begin
         $display("Testbench failed");
      end
      $finish;
   endtask
   task automatic chk(input string name, input logic [31:0] e, input logic [31:0] g);
      n_compared++;
      if (g !== e) begin
         errors++;
         $display("ERROR %s expected %h seen %h", name, e, g);
      end
   endtask
   // One bus cycle; request held until ack is sampled, results taken at that edge.
   task automatic wb(input logic w, input logic [7:0] a, input logic [15:0] d);
      @(posedge clk_i);
      cyc <= 1'b1;
      stb <= 1'b1;
      we <= w;
      adr <= a;
      wdat <= {16'h0000, d};
      sel <= 4'h3;
      do begin
         @(posedge clk_i);
      end while (ack !== 1'b1);
      rdat = rd_o;
      rs_seen = restart;
      ab_seen = abort;
      cyc <= 1'b0;
      stb <= 1'b0;
      we <= 1'b0;
   endtask
   task automatic wait_start();
      int n;
      n = 0;
      do begin
         @(posedge clk_i);
         #1;
         n++;
      end while (start !== 1'b1 && n < 400);
      chk("start", 32'h1, {31'h0, start});
   endtask
   task automatic t_reset();
      for (int i = 0; i < 8; i++) begin
         wb(1'b0, 8'hA0 + 8'(4 * i), 16'h0000);
         chk("setup reset", 32'h00000500, rdat);
      end
   endtask
   task automatic t_mask();
      wb(1'b1, 8'hBC, 16'h7FFF);
      wb(1'b0, 8'hBC, 16'h0000);
      chk("reserved bits", 32'h00000F7F, rdat);
      wb(1'b1, 8'hB8, 16'hFFFF);
      wb(1'b0, 8'hB8, 16'h0000);
      chk("direct word", 32'h0000FFFF, rdat);
      wb(1'b1, 8'hFC, 16'h1234);
      wb(1'b0, 8'hFC, 16'h0000);
      chk("unmapped", 32'h00000000, rdat);
      wb(1'b0, 8'hB8, 16'h0000);
      chk("direct word again", 32'h0000FFFF, rdat);
   endtask
   // Channels 4 and 5 run; setup 6 holds a direct ratio from the mask test.
   task automatic t_restart();
      @(posedge clk_i);
      chan_en <= 16'h0030;
      dly <= 8'h06;
      wait_start();
      wb(1'b1, 8'hA0, 16'h0500);
      chk("restart", 32'h1, {31'h0, rs_seen});
      chk("abort", 32'h1, {31'h0, ab_seen});
      #1;
      chk("first channel", 32'h4, {28'h0, channel});
      wait_start();
      chk("setup ch4", 32'h5, {29'h0, cfg_setup});
      chk("rate ch4", 32'h00BEBC20, {8'h00, centi});
      chk("running", 32'h1, {31'h0, running});
      wait_start();
      chk("next channel", 32'h5, {28'h0, channel});
      chk("direct ch5", 32'h1, {31'h0, direct});
      chk("decim ch5", 32'h00007FFF, {17'h0, decim});
      wb(1'b0, 8'h38, 16'h0000);
      chk("abort seen", 32'h1, {31'h0, rdat[9]});
      wb(1'b0, 8'h38, 16'h0000);
      chk("abort cleared", 32'h0, {31'h0, rdat[9]});
   endtask
   // Each word goes to setup 1, used by channel 0, and is judged at the restarted conversion.
   task automatic t_decode();
      logic [15:0] wd [9] = '{16'h0500, 16'h0A01, 16'h0B02, 16'h0D03, 16'h0E15, 16'h0A65, 16'h0015,
         16'h0003, 16'h8123};
      logic [2:0] fl [9] = '{3'h0, 3'h1, 3'h1, 3'h1, 3'h1, 3'h2, 3'h0, 3'h0, 3'h6};
      logic [23:0] ct [9] = '{24'hBEBC20, 24'h000A8C, 24'h0009C4, 24'h0007D0, 24'h000683, 24'h2625A0,
         24'h0000FA, 24'h5F5E10, 24'h000000};
      logic [9:0] st [9] = '{10'h0, 10'h16F, 10'h190, 10'h1F4, 10'h258, 10'h0, 10'h0, 10'h0, 10'h0};
      @(posedge clk_i);
      chan_en <= 16'h0001;
      dly <= 8'hC8;
      for (int i = 0; i < 9; i++) begin
         wb(1'b1, 8'hA4, wd[i]);
         wait_start();
         chk("flags", {29'h0, fl[i]}, {29'h0, direct, sinc3, post_on});
         chk("rate", {8'h00, ct[i]}, {8'h00, centi});
         chk("settle", {22'h0, st[i]}, {22'h0, settle});
         chk("rate code", {27'h0, wd[i][4:0]}, {27'h0, rate_code});
         chk("post select", {29'h0, wd[i][10:8]}, {29'h0, post_sel});
      end
   endtask
   // Reset for four cycles, then the scenarios in turn.
   initial begin
      repeat (4) @(posedge clk_i);
      rst_i <= 1'b0;
      t_reset();
      t_mask();
      t_restart();
      t_decode();
      end_sim();
   end
endmodule
